// File: design/qrst_switch_timing.sv
// Switch-on/off timing, protections and register slave of the controller.
//
// Contract
// - Valley counter stays within zero to seven, saturating at seven.
// - While off, each zero-cross detection adds one to the valley counter.
// - Valley counter clears whenever the gate drive rises.
// - Output overvoltage while off latches off after a blanking interval.
// - Suppression time is long below the select level, short otherwise.
// - Gate stays low for the whole suppression interval after turn-off.
// - After suppression, turn on once valley count reaches requested count.
// - After maximum off time, turn on regardless of counters.
// - Scaled current above feedback turns the switch off.
// - Current comparators are ignored during leading-edge blanking.
// - Gate is forced off once high longer than maximum on time.
// - Current-limit comparator after blanking turns gate off at once.
// - Short-winding comparator counts only after persisting its blank time.
// - Qualified short-winding during on-time latches the device off.
// - Zero-cross current above threshold yields an offset lowering limit.
// - Burst flag sets on low feedback, count seven and elapsed blank.
// - Requested valley count holds one to seven; writes whose low three bits are zero are ignored.
`timescale 1ns/1ps
module qrst_switch_timing #(
    parameter int FB_W        = 8,
    parameter int MAX_OFF_CYC = qrst_pkg::MAX_OFF_CYC_DFLT
) (
    // Clock and reset
    input  wire logic                       core_clk_i,
    input  wire logic                       rst_n_i,
    // Comparator outputs and foldback measure
    input  wire qrst_pkg::qrst_cmp_s        cmp_i,
    input  wire logic [FB_W-1:0]            zc_excess_i,
    // Power stage and status outputs
    output logic                            gate_drive_out_o,
    output logic [FB_W-1:0]                 cs_offset_o,
    output logic                            burst_o,
    output logic                            latched_o,
    output logic                            irq_o,
    // Avalon-MM slave
    input  wire logic [5:0]                 avs_address_i,
    input  wire logic                       avs_read_i,
    input  wire logic                       avs_write_i,
    input  wire logic [31:0]                avs_writedata_i,
    input  wire logic [3:0]                 avs_byteenable_i,
    output logic [31:0]                     avs_readdata_o,
    output logic                            avs_waitrequest_o
);
    import qrst_pkg::*;

    localparam logic [OFF_W-1:0] OFF_LAST = OFF_W'(MAX_OFF_CYC - 1);

    function automatic logic addr_hit(input logic [5:0] a,
                                      input logic [5:0] ofs);
        return a == ofs;
    endfunction : addr_hit

    qrst_cmp_s          cmp_s1_r;
    qrst_cmp_s          cmp_s2_r;
    logic               zc_prev_r;
    logic               zc_rise;
    qrst_state_e        state_r;
    qrst_state_e        state_nxt;
    logic [2:0]         valley_r;
    logic [2:0]         udc_r;
    logic [CNT_W-1:0]   on_cnt_r;
    logic [CNT_W-1:0]   supp_cnt_r;
    logic [CNT_W-1:0]   ovp_cnt_r;
    logic [CNT_W-1:0]   sw_cnt_r;
    logic [CNT_W-1:0]   beb_cnt_r;
    logic [OFF_W-1:0]   off_cnt_r;
    logic [FB_W-1:0]    offset_r;
    logic               sw_off;
    logic               gate_on;
    logic               turn_on;
    logic               turn_off;
    logic               ovp_fire;
    logic               sw_fire;
    logic               latch_go;
    logic               cs_trip;
    logic               burst_cond;
    logic               burst_set;
    logic               burst_r;
    logic               run_r;
    logic               ack_r;
    logic               wr_en;
    logic               burst_clr;
    logic [IRQ_W-1:0]   irq_stat_r;
    logic [IRQ_W-1:0]   irq_en_r;
    logic [IRQ_W-1:0]   irq_ev;
    logic [31:0]        status_w;

    // ****************************************************************
    // Comparator synchronisers
    // ****************************************************************
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cmp_s1_r  <= '0;
            cmp_s2_r  <= '0;
            zc_prev_r <= 1'b0;
        end else begin
            cmp_s1_r  <= cmp_i;
            cmp_s2_r  <= cmp_s1_r;
            zc_prev_r <= cmp_s2_r.zc_cross;
        end
    end

    assign zc_rise = cmp_s2_r.zc_cross & ~zc_prev_r;

    // ****************************************************************
    // Switch state machine
    // ****************************************************************
    assign gate_on  = (state_r == ST_ON);
    assign sw_off   = (state_r == ST_WAIT) || (state_r == ST_SUPP);
    assign ovp_fire = sw_off && cmp_s2_r.ovp
                      && (ovp_cnt_r == OVP_BLANK_CYC - 12'h001);
    assign sw_fire  = gate_on && cmp_s2_r.sw_short
                      && (sw_cnt_r == SW_BLANK_CYC - 12'h001);
    assign latch_go = ovp_fire || sw_fire;
    // Current comparators only count once blanking has run out.
    assign cs_trip  = (on_cnt_r >= LEB_CYC)
                      && (cmp_s2_r.cs_pwm || cmp_s2_r.cs_limit);

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_WAIT: begin
                if (latch_go) begin
                    state_nxt = ST_LATCH;
                end else if (run_r && !burst_r
                             && (valley_r >= udc_r
                                 || off_cnt_r >= OFF_LAST)) begin
                    state_nxt = ST_ON;
                end
            end
            ST_SUPP: begin
                if (latch_go) begin
                    state_nxt = ST_LATCH;
                end else if (supp_cnt_r == '0) begin
                    state_nxt = ST_WAIT;
                end
            end
            ST_ON: begin
                if (latch_go) begin
                    state_nxt = ST_LATCH;
                end else if (cs_trip
                             || on_cnt_r == MAX_ON_CYC) begin
                    state_nxt = ST_SUPP;
                end
            end
            ST_LATCH: begin
                state_nxt = ST_LATCH;
            end
        endcase
    end

    assign turn_on  = !gate_on && (state_nxt == ST_ON);
    assign turn_off = gate_on && (state_nxt == ST_SUPP);

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= ST_WAIT;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign gate_drive_out_o = gate_on;
    assign latched_o        = (state_r == ST_LATCH);

    // ****************************************************************
    // Valley counter
    // ****************************************************************
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            valley_r <= 3'h0;
        end else if (turn_on) begin
            valley_r <= 3'h0;
        end else if (sw_off && zc_rise && valley_r < VALLEY_MAX) begin
            valley_r <= valley_r + 3'h1;
        end
    end

    // ****************************************************************
    // Timers
    // ****************************************************************
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            on_cnt_r <= '0;
        end else if (turn_on) begin
            on_cnt_r <= '0;
        end else if (gate_on && on_cnt_r < MAX_ON_CYC) begin
            on_cnt_r <= on_cnt_r + 12'h001;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            supp_cnt_r <= '0;
        end else if (turn_off) begin
            supp_cnt_r <= cmp_s2_r.supp_hi ? SUPP_SHORT_CYC - 12'h001
                                           : SUPP_LONG_CYC - 12'h001;
        end else if (state_r == ST_SUPP && supp_cnt_r != '0) begin
            supp_cnt_r <= supp_cnt_r - 12'h001;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            off_cnt_r <= '0;
        end else if (gate_on) begin
            off_cnt_r <= '0;
        end else if (off_cnt_r < OFF_LAST) begin
            off_cnt_r <= off_cnt_r + 20'h0_0001;
        end
    end

    // ****************************************************************
    // Protection blanking
    // ****************************************************************
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ovp_cnt_r <= '0;
        end else if (!(sw_off && cmp_s2_r.ovp)) begin
            ovp_cnt_r <= '0;
        end else if (ovp_cnt_r < OVP_BLANK_CYC - 12'h001) begin
            ovp_cnt_r <= ovp_cnt_r + 12'h001;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sw_cnt_r <= '0;
        end else if (!(gate_on && cmp_s2_r.sw_short)) begin
            sw_cnt_r <= '0;
        end else if (sw_cnt_r < SW_BLANK_CYC - 12'h001) begin
            sw_cnt_r <= sw_cnt_r + 12'h001;
        end
    end

    // ****************************************************************
    // Foldback offset and burst entry
    // ****************************************************************
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            offset_r <= '0;
        end else begin
            offset_r <= cmp_s2_r.fb_over ? zc_excess_i : '0;
        end
    end

    assign cs_offset_o = offset_r;
    assign burst_cond  = cmp_s2_r.fb_burst && (udc_r == VALLEY_MAX);
    assign burst_set   = !burst_r && burst_cond
                         && (beb_cnt_r == BEB_CYC - 12'h001);

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            beb_cnt_r <= '0;
        end else if (!burst_cond) begin
            beb_cnt_r <= '0;
        end else if (beb_cnt_r < BEB_CYC - 12'h001) begin
            beb_cnt_r <= beb_cnt_r + 12'h001;
        end
    end

    // A set in the same cycle as a software clear wins.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            burst_r <= 1'b0;
        end else if (burst_set) begin
            burst_r <= 1'b1;
        end else if (burst_clr) begin
            burst_r <= 1'b0;
        end
    end

    assign burst_o = burst_r;

    // ****************************************************************
    // Avalon-MM slave with one wait state
    // ****************************************************************
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_r;
    assign wr_en     = avs_write_i & ack_r & avs_byteenable_i[0];
    assign burst_clr = wr_en && addr_hit(avs_address_i, CTRL_OFS)
                       && avs_writedata_i[CTRL_BCLR_BIT];

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (avs_read_i | avs_write_i) & ~ack_r;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            run_r    <= 1'b0;
            irq_en_r <= '0;
        end else if (wr_en && addr_hit(avs_address_i, CTRL_OFS)) begin
            run_r    <= avs_writedata_i[CTRL_RUN_BIT];
        end else if (wr_en && addr_hit(avs_address_i, IRQ_EN_OFS)) begin
            irq_en_r <= avs_writedata_i[IRQ_W-1:0];
        end
    end

    // Zero is outside the legal range and is dropped.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            udc_r <= UDC_RST;
        end else if (wr_en && addr_hit(avs_address_i, VREQ_OFS)
                     && avs_writedata_i[2:0] >= UDC_MIN) begin
            udc_r <= avs_writedata_i[2:0];
        end
    end

    always_comb begin
        irq_ev                = '0;
        irq_ev[IRQ_ON_BIT]    = turn_on;
        irq_ev[IRQ_OFF_BIT]   = turn_off;
        irq_ev[IRQ_LATCH_BIT] = latch_go && !latched_o;
        irq_ev[IRQ_BURST_BIT] = burst_set;
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_stat_r <= '0;
        end else if (wr_en && addr_hit(avs_address_i, IRQ_CLR_OFS)) begin
            irq_stat_r <= (irq_stat_r & ~avs_writedata_i[IRQ_W-1:0])
                          | irq_ev;
        end else begin
            irq_stat_r <= irq_stat_r | irq_ev;
        end
    end

    assign irq_o = |(irq_stat_r & irq_en_r);

    always_comb begin
        status_w                             = '0;
        status_w[ST_STATE_LSB +: 2]          = state_r;
        status_w[ST_GATE_BIT]                = gate_on;
        status_w[ST_LATCH_BIT]               = latched_o;
        status_w[ST_BURST_BIT]               = burst_r;
        status_w[ST_VALLEY_LSB +: 3]         = valley_r;
        status_w[ST_UDC_LSB +: 3]            = udc_r;
        status_w[ST_OFS_LSB +: FB_W]         = offset_r;
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (avs_read_i && !ack_r) begin
            case (avs_address_i)
                CTRL_OFS:     avs_readdata_o <= {31'h0000_0000, run_r};
                VREQ_OFS:     avs_readdata_o <= {29'h0000_0000, udc_r};
                STATUS_OFS:   avs_readdata_o <= status_w;
                IRQ_STAT_OFS: avs_readdata_o <= {28'h000_0000, irq_stat_r};
                IRQ_EN_OFS:   avs_readdata_o <= {28'h000_0000, irq_en_r};
                default:      avs_readdata_o <= 32'h0000_0000;
            endcase
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    valley_bound_a: assert property (
        valley_r <= VALLEY_MAX)
        else $error("valley counter above seven");
    valley_count_a: assert property (
        sw_off && zc_rise && valley_r < VALLEY_MAX && !turn_on
        |=> valley_r == 3'($past(valley_r) + 3'h1))
        else $error("zero crossing not counted");
    valley_clear_a: assert property (
        $rose(gate_drive_out_o) |-> valley_r == 3'h0)
        else $error("valley counter not cleared on turn-on");
    ovp_latch_a: assert property (
        sw_off && cmp_s2_r.ovp && ovp_cnt_r == OVP_BLANK_CYC - 12'h001
        |=> latched_o)
        else $error("overvoltage did not latch off");
    supp_len_a: assert property (
        $fell(gate_drive_out_o) && state_r == ST_SUPP
        |-> supp_cnt_r == ($past(cmp_s2_r.supp_hi)
                           ? SUPP_SHORT_CYC - 12'h001
                           : SUPP_LONG_CYC - 12'h001))
        else $error("wrong suppression length");
    supp_hold_a: assert property (
        state_r == ST_SUPP |=> !gate_drive_out_o)
        else $error("gate rose during suppression");
    valley_on_a: assert property (
        state_r == ST_WAIT && valley_r >= udc_r && run_r && !burst_r
        && !latch_go |=> gate_drive_out_o)
        else $error("valley turn-on missed");
    max_off_a: assert property (
        state_r == ST_WAIT && off_cnt_r >= OFF_LAST && run_r
        && !burst_r && !latch_go |=> gate_drive_out_o)
        else $error("maximum off time turn-on missed");
    pwm_off_a: assert property (
        gate_on && on_cnt_r >= LEB_CYC && cmp_s2_r.cs_pwm
        |=> !gate_drive_out_o)
        else $error("peak current did not switch off");
    leb_hold_a: assert property (
        gate_on && on_cnt_r < LEB_CYC |=> gate_drive_out_o || latched_o)
        else $error("gate fell inside blanking");
    max_on_a: assert property (
        gate_on |-> on_cnt_r <= MAX_ON_CYC)
        else $error("on time exceeded maximum");
    ilim_off_a: assert property (
        gate_on && on_cnt_r >= LEB_CYC && cmp_s2_r.cs_limit
        |=> !gate_drive_out_o)
        else $error("current limit did not switch off");
    sw_blank_a: assert property (
        state_r == ST_ON && sw_cnt_r < SW_BLANK_CYC - 12'h001
        && !ovp_fire |=> !latched_o)
        else $error("short winding latched before blanking");
    sw_latch_a: assert property (
        gate_on && cmp_s2_r.sw_short
        && sw_cnt_r == SW_BLANK_CYC - 12'h001 |=> latched_o)
        else $error("short winding did not latch off");
    ofs_zero_a: assert property (
        !cmp_s2_r.fb_over |=> cs_offset_o == '0)
        else $error("offset without foldback current");
    burst_set_a: assert property (
        $rose(burst_o) |-> $past(udc_r) == VALLEY_MAX
        && $past(beb_cnt_r) == BEB_CYC - 12'h001
        && $past(cmp_s2_r.fb_burst))
        else $error("burst set without its conditions");
    udc_range_a: assert property (
        udc_r >= UDC_MIN)
        else $error("requested valley count out of range");
    latch_hold_a: assert property (
        latched_o |=> latched_o && !gate_drive_out_o)
        else $error("latched-off state left");

    valley_turn_c: cover property (valley_r >= 3'h2 && turn_on);
    off_max_c: cover property (off_cnt_r >= OFF_LAST && turn_on);
    latch_c: cover property ($rose(latched_o));
    burst_c: cover property ($rose(burst_o));

endmodule : qrst_switch_timing

// File: design/qrst_pkg.sv
// Constants and types shared by the quasi-resonant switch timing block.
package qrst_pkg;

    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS   = 10;
    localparam int CNT_W           = 12;
    localparam int OFF_W           = 20;
    localparam int SUPP_LONG_NS    = 2500;
    localparam int SUPP_SHORT_NS   = 1000;
    localparam int LEB_NS          = 220;
    localparam int MAX_ON_NS       = 25000;
    localparam int SW_BLANK_NS     = 190;
    localparam int OVP_BLANK_NS    = 5000;
    localparam int BEB_NS          = 20000;
    localparam int MAX_OFF_NS      = 50000;
    // Least times round up, longest times round down.
    localparam logic [CNT_W-1:0] SUPP_LONG_CYC =
        12'((SUPP_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] SUPP_SHORT_CYC =
        12'((SUPP_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] LEB_CYC =
        12'((LEB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] MAX_ON_CYC =
        12'(MAX_ON_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] SW_BLANK_CYC =
        12'((SW_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] OVP_BLANK_CYC =
        12'((OVP_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] BEB_CYC =
        12'((BEB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int MAX_OFF_CYC_DFLT = MAX_OFF_NS / CLK_PERIOD_NS;

    // ****************************************************************
    // Counters
    // ****************************************************************
    localparam logic [2:0] VALLEY_MAX = 3'h7;
    localparam logic [2:0] UDC_MIN    = 3'h1;
    localparam logic [2:0] UDC_RST    = 3'h1;

    // ****************************************************************
    // Register map and fields
    // ****************************************************************
    localparam logic [5:0] CTRL_OFS     = 6'h00;
    localparam logic [5:0] VREQ_OFS     = 6'h04;
    localparam logic [5:0] STATUS_OFS   = 6'h08;
    localparam logic [5:0] IRQ_STAT_OFS = 6'h0C;
    localparam logic [5:0] IRQ_EN_OFS   = 6'h10;
    localparam logic [5:0] IRQ_CLR_OFS  = 6'h14;
    localparam int CTRL_RUN_BIT   = 0;
    localparam int CTRL_BCLR_BIT  = 1;
    localparam int ST_STATE_LSB   = 0;
    localparam int ST_GATE_BIT    = 2;
    localparam int ST_LATCH_BIT   = 3;
    localparam int ST_BURST_BIT   = 4;
    localparam int ST_VALLEY_LSB  = 8;
    localparam int ST_UDC_LSB     = 12;
    localparam int ST_OFS_LSB     = 16;
    localparam int IRQ_W          = 4;
    localparam int IRQ_ON_BIT     = 0;
    localparam int IRQ_OFF_BIT    = 1;
    localparam int IRQ_LATCH_BIT  = 2;
    localparam int IRQ_BURST_BIT  = 3;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        ST_WAIT  = 2'b00,
        ST_SUPP  = 2'b01,
        ST_ON    = 2'b10,
        ST_LATCH = 2'b11
    } qrst_state_e;

    typedef struct packed {
        logic zc_cross;
        logic ovp;
        logic supp_hi;
        logic cs_pwm;
        logic cs_limit;
        logic sw_short;
        logic fb_burst;
        logic fb_over;
    } qrst_cmp_s;

endpackage : qrst_pkg

// File: test/qrst_partner.sv
// Behavioural power stage and comparators facing the switch timing block.
`timescale 1ns/1ps
module qrst_partner (
    // Clock and gate
    input  wire logic           clk_i,
    input  wire logic           gate_i,
    // Scenario knobs: ringing, current, short winding, foldback,
    // output overvoltage, low feedback
    input  wire logic [5:0]     knob_i,
    // Comparator outputs
    output qrst_pkg::qrst_cmp_s cmp_o
);
    import qrst_pkg::*;
    logic [3:0] ph_r = 4'h0;
    always_ff @(posedge clk_i) ph_r <= ph_r + 4'h1;
    // Valleys ring only while off; sensed current exists only while on.
    assign cmp_o = '{zc_cross: knob_i[0] & ~gate_i & ph_r[2],
                     ovp: knob_i[4] & ~gate_i, supp_hi: ph_r[3],
                     cs_pwm: gate_i & knob_i[1],
                     cs_limit: gate_i & knob_i[1] & ph_r[0],
                     sw_short: gate_i & knob_i[2],
                     fb_burst: knob_i[5], fb_over: knob_i[3]};
endmodule : qrst_partner

// File: test/tb.sv
// Self-checking bench for the switch timing block.
`timescale 1ns/1ps
module tb;
    import qrst_pkg::*;
    localparam int MOFF = 400;
    logic        clk, rst_n, rd, wr, gate, irq, lat, wreq, bst;
    logic [5:0]  addr;
    logic [31:0] wd, rdat, q;
    logic [5:0]  knob;
    logic [7:0]  exc, ofs;
    qrst_cmp_s   cmp;
    int          error_cnt, comparisons, hi, lo;
    int          exp_q[$];
    qrst_partner i_far (.clk_i(clk), .gate_i(gate), .knob_i(knob),
        .cmp_o(cmp));
    qrst_switch_timing #(.MAX_OFF_CYC(MOFF)) i_dut (.core_clk_i(clk),
        .rst_n_i(rst_n), .cmp_i(cmp), .zc_excess_i(exc),
        .gate_drive_out_o(gate), .cs_offset_o(ofs), .burst_o(bst),
        .latched_o(lat), .irq_o(irq), .avs_address_i(addr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
        .avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wreq));
    task end_sim;
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        wr   <= w;
        rd   <= ~w;
        addr <= a;
        wd   <= d;
        // The request holds until a rising edge samples waitrequest low.
        @(posedge clk);
        while (wreq !== 1'b0) @(posedge clk);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus
    // Pulse widths are compared against queued notes; off times against
    // the suppression floor and the off-time ceiling.
    always @(negedge clk) begin
        if (gate === 1'b1) begin
            if (lo > 0) begin
                chk(32'(lo >= 100 && lo <= MOFF + 2), 1);
            end
            lo = 0;
            hi++;
        end else begin
            if (hi > 0 && exp_q.size() > 0) begin
                chk(hi, exp_q.pop_front());
            end
            if (hi > 0) lo = 1; else if (lo > 0) lo++;
            hi = 0;
        end
    end
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #200us;
        error_cnt++;
        end_sim();
    end
    initial begin
        rst_n = 1'b0; rd = 1'b0; wr = 1'b0; addr = '0; wd = '0;
        knob = 6'h00; exc = 8'h00; q = '0;
        error_cnt = 0; comparisons = 0; hi = 0; lo = 0;
        void'($urandom(32'h45f1));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        bus(0, STATUS_OFS, 0); chk(q, 32'h0000_1000);
        bus(1, VREQ_OFS, 0); bus(0, VREQ_OFS, 0); chk(q, 1);
        bus(0, 6'h3C, 0); chk(q, 0);
        bus(1, IRQ_EN_OFS, 32'h0000_000F);
        knob <= 6'h03;
        repeat (3) exp_q.push_back(23);
        bus(1, CTRL_OFS, 1);
        repeat (3) @(negedge gate);
        // No ringing: the next turn-on waits for the maximum off time.
        knob <= 6'h00;
        exp_q.push_back(2501);
        chk(irq, 1);
        @(negedge gate);
        exc <= 8'($urandom);
        knob <= 6'h09;
        repeat (5) @(negedge clk);
        chk(ofs, exc);
        knob <= 6'h05;
        repeat (400) @(negedge clk);
        chk(lat, 1); chk(gate, 0); chk(ofs, 0);
        repeat (300) @(negedge clk);
        chk(gate, 0);
        bus(0, STATUS_OFS, 0); chk(q[3:0], 4'hB);
        bus(0, IRQ_STAT_OFS, 0); chk(q, 7);
        bus(1, IRQ_CLR_OFS, 3); bus(0, IRQ_STAT_OFS, 0); chk(q, 4);
        bus(1, IRQ_EN_OFS, 3);
        @(negedge clk);
        chk(irq, 0);
        // Second reset, then burst entry and the overvoltage latch-off.
        @(posedge clk);
        rst_n <= 1'b0;
        knob  <= 6'h00;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        bus(1, VREQ_OFS, 7);
        knob <= 6'h20;
        repeat (2000) @(negedge clk);
        chk(bst, 0);
        repeat (4) @(negedge clk);
        chk(bst, 1);
        knob <= 6'h00;
        bus(1, CTRL_OFS, 32'h0000_0002);
        bus(0, STATUS_OFS, 0);
        chk(q[ST_BURST_BIT], 0);
        chk(bst, 0);
        bus(0, IRQ_STAT_OFS, 0);
        chk(q, 32'h0000_0008);
        knob <= 6'h10;
        repeat (500) @(negedge clk);
        chk(lat, 0);
        repeat (4) @(negedge clk);
        chk(lat, 1);
        end_sim();
    end
endmodule : tb
